// >>> hdl/msbp_pkg.sv
package msbp_pkg;

	// Bus geometry
	localparam int unsigned AD_W      = 16;
	localparam int unsigned LANE_W    = 8;
	localparam int unsigned STATUS_W  = 4;
	localparam int unsigned MEM_AW    = 4;
	localparam int unsigned MEM_DEPTH = 16;

	// Reset levels of driven lines
	localparam logic RST_STROBE_N = 1'b1;
	localparam logic RST_OE_N     = 1'b1;
	localparam logic RST_RD       = 1'b1;
	localparam logic [AD_W-1:0] RST_WORD = 16'h0000;

	// Transaction kinds, low two status lines
	typedef enum logic [1:0] {
		MSBP_KIND_NULL = 2'b00,
		MSBP_KIND_IO   = 2'b01,
		MSBP_KIND_MEM  = 2'b10
	} msbp_kind_t;

	// Master sequencer, one step per bus clock rising edge
	typedef enum logic [2:0] {
		MSBP_M_IDLE = 3'b000,
		MSBP_M_ADDR = 3'b001,
		MSBP_M_ASHI = 3'b010,
		MSBP_M_DSLO = 3'b011,
		MSBP_M_DATA = 3'b100,
		MSBP_M_END  = 3'b101
	} msbp_mstate_t;

	// Responder sequencer
	typedef enum logic [2:0] {
		MSBP_R_IDLE = 3'b000,
		MSBP_R_SEL  = 3'b001,
		MSBP_R_RDWT = 3'b010,
		MSBP_R_DRV  = 3'b011,
		MSBP_R_WR   = 3'b100
	} msbp_rstate_t;

	// Request from the user side of the master
	typedef struct packed {
		logic [1:0]      qual;
		msbp_kind_t      kind;
		logic            rd;
		logic            byte_sz;
		logic [AD_W-1:0] addr;
		logic [AD_W-1:0] wdata;
	} msbp_mreq_t;

	// Bus lines seen by the block, all asynchronous to i_clk
	typedef struct packed {
		logic                bus_clk;
		logic                as_n;
		logic                ds_n;
		logic                rd;
		logic                byte_sz;
		logic                cs_n;
		logic                wait_n;
		logic                reset_n;
		logic                bus_ownership_request_n_n;
		logic                grant_in_n;
		logic                bus_grant_ack_n_n;
		logic [STATUS_W-1:0] status;
		logic [AD_W-1:0]     ad;
	} msbp_pins_t;

	localparam int unsigned PINS_W = $bits(msbp_pins_t);

	// Places a byte on both lanes, or passes a word
	function automatic logic [AD_W-1:0] lane_fit(input logic [AD_W-1:0] w,
			input logic byte_sz, input logic hi);
		logic [LANE_W-1:0] b;
		b = hi ? w[AD_W-1:LANE_W] : w[LANE_W-1:0];
		lane_fit = byte_sz ? {b, b} : w;
	endfunction

endpackage

// >>> hdl/msbp_sync.sv
`timescale 1ns/1ns
module msbp_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Asynchronous in, synchronised out
	input  wire logic [W-1:0] i_async,
	input  wire logic [W-1:0] i_rst_val,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	// Idle levels stand in until both stages hold real samples after reset
	logic [1:0] fill_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fill_q <= 2'b00;
		end else begin
			fill_q <= {fill_q[0], 1'b1};
		end
	end

	assign o_sync = fill_q[1] ? sync_q : i_rst_val;

endmodule // msbp_sync

// >>> hdl/msbp_mem.sv
`timescale 1ns/1ns
module msbp_mem (
	// Clock
	input  wire logic                            i_clk,
	// Write port with byte enables
	input  wire logic                            i_we,
	input  wire logic [1:0]                      i_be,
	input  wire logic [msbp_pkg::MEM_AW-1:0]     i_waddr,
	input  wire logic [msbp_pkg::AD_W-1:0]       i_wdata,
	// Read port, data one cycle after address
	input  wire logic [msbp_pkg::MEM_AW-1:0]     i_raddr,
	output logic      [msbp_pkg::AD_W-1:0]       o_rdata
);

	logic [msbp_pkg::AD_W-1:0] mem_q [msbp_pkg::MEM_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we && i_be[0]) begin
			mem_q[i_waddr][msbp_pkg::LANE_W-1:0] <= i_wdata[msbp_pkg::LANE_W-1:0];
		end
		if (i_we && i_be[1]) begin
			mem_q[i_waddr][msbp_pkg::AD_W-1:msbp_pkg::LANE_W] <=
				i_wdata[msbp_pkg::AD_W-1:msbp_pkg::LANE_W];
		end
		o_rdata <= mem_q[i_raddr];
	end

endmodule // msbp_mem

// >>> hdl/msbp_port.sv
// Overview of operation
// - Shared lines carry address then data
// - Narrow bus uses low eight lines only
// - Data strobe times every data movement
// - Direction line: low write, high read
// - Size line: low word, absent when narrow; code drives it high (byte) on a narrow bus
// - Responder pulls extend-request; master lengthens
// - Reset line low resets all bus logic
// - Both strobes low also reset responder
// - Select latched at address strobe rise
// - Master outputs follow bus clock edges
// - Responder follows strobes, not bus clock
// - Requester holds ownership request low
// - CPU acknowledges only after yielding bus
// - Grant passes down an in/out chain
// - One transaction at once, master starts
// - Memory and I/O move 8 or 16 bits
// - Null transaction moves no data
// - Peripheral answers I/O, raises interrupts
// - CPU role owns the bus by default
// - Bus request answered by acknowledge signal
`timescale 1ns/1ns
module msbp_port (
	// Clock and reset
	input  wire logic                           i_clk,
	input  wire logic                           i_rst,
	// Straps
	input  wire logic                           i_cpu_role,
	input  wire logic                           i_narrow_bus,
	// Bus inputs
	input  wire msbp_pkg::msbp_pins_t           i_pins,
	// Multiplexed lines and master control outputs
	output logic      [msbp_pkg::AD_W-1:0]      o_mux_addr_data_lines,
	output logic      [1:0]                     o_ad_oe_n,
	output logic                                o_addr_valid_strobe_n,
	output logic                                o_transfer_timing_strobe_n,
	output logic                                o_rd,
	output logic                                o_byte_sz,
	output logic      [msbp_pkg::STATUS_W-1:0]  o_status,
	output logic                                o_ctl_oe_n,
	// Open-drain lines
	output logic                                o_wait_oe_n,
	output logic                                o_bus_ownership_request_oe_n,
	// Grant and interrupt outputs
	output logic                                o_bus_grant_ack_n,
	output logic                                o_grant_chain_out_n,
	output logic                                o_int_req_n,
	// Master user side
	input  wire msbp_pkg::msbp_mreq_t           i_mreq,
	input  wire logic                           i_mreq_valid,
	output logic                                o_mreq_ready,
	output logic                                o_mdone,
	output logic      [msbp_pkg::AD_W-1:0]      o_mrdata,
	// Peripheral user side
	input  wire logic                           i_irq_req
);

	msbp_pkg::msbp_pins_t pins_s;
	msbp_pkg::msbp_pins_t idle_pins;
	logic                 bclk_q;
	logic                 as_q;
	logic                 ds_q;

	always_comb begin
		idle_pins            = '0;
		idle_pins.bus_clk    = 1'b0;
		idle_pins.as_n       = 1'b1;
		idle_pins.ds_n       = 1'b1;
		idle_pins.cs_n       = 1'b1;
		idle_pins.wait_n     = 1'b1;
		idle_pins.reset_n    = 1'b1;
		idle_pins.bus_ownership_request_n_n   = 1'b1;
		idle_pins.grant_in_n = 1'b1;
		idle_pins.bus_grant_ack_n_n   = 1'b1;
	end

	msbp_sync #(
		.W(msbp_pkg::PINS_W)
	) u_sync (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_async  (i_pins),
		.i_rst_val(idle_pins),
		.o_sync   (pins_s)
	);

	// Edge history of synchronised lines
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bclk_q <= 1'b0;
			as_q   <= 1'b1;
			ds_q   <= 1'b1;
		end else begin
			bclk_q <= pins_s.bus_clk;
			as_q   <= pins_s.as_n;
			ds_q   <= pins_s.ds_n;
		end
	end

	logic bclk_rise;
	logic as_rise;
	logic ds_fall;
	logic ds_rise;
	logic bus_rst;
	logic strobe_rst;

	assign bclk_rise  = pins_s.bus_clk & ~bclk_q;
	assign as_rise    = pins_s.as_n & ~as_q;
	assign ds_fall    = ~pins_s.ds_n & ds_q;
	assign ds_rise    = pins_s.ds_n & ~ds_q;
	assign bus_rst    = ~pins_s.reset_n;
	assign strobe_rst = ~pins_s.as_n & ~pins_s.ds_n;

	// ---------------- Ownership and grant chain ----------------
	msbp_pkg::msbp_mstate_t m_state_q;
	logic                   grant_q;
	logic                   ack_q;
	logic                   m_idle;
	logic                   own_bus;
	logic                   want_bus;

	assign m_idle   = (m_state_q == msbp_pkg::MSBP_M_IDLE);
	assign want_bus = ~i_cpu_role & (i_mreq_valid | ~m_idle | grant_q);
	assign own_bus  = i_cpu_role ? ~ack_q : grant_q;

	// Requester takes the grant when it arrives while asking
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			grant_q <= 1'b0;
		end else if (bus_rst || i_cpu_role) begin
			grant_q <= 1'b0;
		end else if (!grant_q && i_mreq_valid && !pins_s.grant_in_n) begin
			grant_q <= 1'b1;
		end else if (grant_q && m_idle && !i_mreq_valid) begin
			grant_q <= 1'b0;
		end
	end

	// CPU yields only from idle, then acknowledges
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_q <= 1'b0;
		end else if (bus_rst || !i_cpu_role) begin
			ack_q <= 1'b0;
		end else if (!ack_q && !pins_s.bus_ownership_request_n_n && m_idle) begin
			ack_q <= 1'b1;
		end else if (ack_q && pins_s.bus_ownership_request_n_n) begin
			ack_q <= 1'b0;
		end
	end

	assign o_bus_grant_ack_n            = ~(ack_q & o_ctl_oe_n);
	assign o_bus_ownership_request_oe_n = ~want_bus;
	assign o_grant_chain_out_n          = want_bus ? 1'b1 : pins_s.grant_in_n;
	assign o_int_req_n                  = ~i_irq_req;

	// ---------------- Master sequencer ----------------
	msbp_pkg::msbp_mreq_t cur_q;
	logic                 m_start;

	assign o_mreq_ready = m_idle & own_bus & ~bus_rst;
	assign m_start      = o_mreq_ready & i_mreq_valid & bclk_rise;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			m_state_q <= msbp_pkg::MSBP_M_IDLE;
		end else if (bus_rst) begin
			m_state_q <= msbp_pkg::MSBP_M_IDLE;
		end else if (bclk_rise) begin
			case (m_state_q)
				msbp_pkg::MSBP_M_IDLE: begin
					if (m_start) begin
						m_state_q <= msbp_pkg::MSBP_M_ADDR;
					end
				end
				msbp_pkg::MSBP_M_ADDR: begin
					m_state_q <= msbp_pkg::MSBP_M_ASHI;
				end
				msbp_pkg::MSBP_M_ASHI: begin
					if (cur_q.kind == msbp_pkg::MSBP_KIND_NULL) begin
						m_state_q <= msbp_pkg::MSBP_M_END;
					end else begin
						m_state_q <= msbp_pkg::MSBP_M_DSLO;
					end
				end
				msbp_pkg::MSBP_M_DSLO: begin
					m_state_q <= msbp_pkg::MSBP_M_DATA;
				end
				msbp_pkg::MSBP_M_DATA: begin
					if (pins_s.wait_n) begin
						m_state_q <= msbp_pkg::MSBP_M_END;
					end
				end
				msbp_pkg::MSBP_M_END: begin
					m_state_q <= msbp_pkg::MSBP_M_IDLE;
				end
				default: begin
					m_state_q <= msbp_pkg::MSBP_M_IDLE;
				end
			endcase
		end
	end

	// Request held for the whole transaction
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cur_q <= '0;
		end else if (m_start) begin
			cur_q         <= i_mreq;
			cur_q.byte_sz <= i_mreq.byte_sz | i_narrow_bus;
		end
	end

	// Completion pulse and read data capture
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mdone  <= 1'b0;
			o_mrdata <= msbp_pkg::RST_WORD;
		end else begin
			o_mdone <= bclk_rise & (m_state_q == msbp_pkg::MSBP_M_END) & ~bus_rst;
			if (bclk_rise && m_state_q == msbp_pkg::MSBP_M_DATA && pins_s.wait_n
					&& cur_q.rd) begin
				o_mrdata <= cur_q.byte_sz ?
					{{msbp_pkg::LANE_W{1'b0}}, pins_s.ad[msbp_pkg::LANE_W-1:0]} :
					pins_s.ad;
			end
		end
	end

	// ---------------- Responder ----------------
	msbp_pkg::msbp_rstate_t  r_state_q;
	logic [msbp_pkg::AD_W-1:0] r_addr_q;
	logic                    r_rd_q;
	logic                    r_byte_q;
	logic                    r_we;
	logic [1:0]              r_be;
	logic [msbp_pkg::AD_W-1:0] mem_rdata;
	logic                    r_hit;

	// Select counts only for data-moving kinds, sampled at strobe rise
	assign r_hit = ~pins_s.cs_n
		& (pins_s.status[1:0] != msbp_pkg::MSBP_KIND_NULL);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r_state_q <= msbp_pkg::MSBP_R_IDLE;
		end else if (bus_rst || strobe_rst || i_cpu_role) begin
			r_state_q <= msbp_pkg::MSBP_R_IDLE;
		end else begin
			case (r_state_q)
				msbp_pkg::MSBP_R_IDLE: begin
					if (as_rise && r_hit && m_idle) begin
						r_state_q <= msbp_pkg::MSBP_R_SEL;
					end
				end
				msbp_pkg::MSBP_R_SEL: begin
					if (as_rise && !r_hit) begin
						r_state_q <= msbp_pkg::MSBP_R_IDLE;
					end else if (ds_fall) begin
						r_state_q <= r_rd_q ? msbp_pkg::MSBP_R_RDWT : msbp_pkg::MSBP_R_WR;
					end
				end
				msbp_pkg::MSBP_R_RDWT: begin
					r_state_q <= msbp_pkg::MSBP_R_DRV;
				end
				msbp_pkg::MSBP_R_DRV: begin
					if (ds_rise) begin
						r_state_q <= msbp_pkg::MSBP_R_IDLE;
					end
				end
				msbp_pkg::MSBP_R_WR: begin
					if (ds_rise) begin
						r_state_q <= msbp_pkg::MSBP_R_IDLE;
					end
				end
				default: begin
					r_state_q <= msbp_pkg::MSBP_R_IDLE;
				end
			endcase
		end
	end

	// Address and attributes latched with the select
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r_addr_q <= msbp_pkg::RST_WORD;
			r_rd_q   <= msbp_pkg::RST_RD;
			r_byte_q <= 1'b0;
		end else if (as_rise) begin
			r_addr_q <= pins_s.ad;
			r_rd_q   <= pins_s.rd;
			r_byte_q <= pins_s.byte_sz | i_narrow_bus;
		end
	end

	// Write data taken from the lines as the data strobe ends
	assign r_we = (r_state_q == msbp_pkg::MSBP_R_WR) & ds_rise & ~strobe_rst & ~bus_rst;
	assign r_be = r_byte_q ? {r_addr_q[0], ~r_addr_q[0]} : 2'b11;

	msbp_mem u_mem (
		.i_clk  (i_clk),
		.i_we   (r_we),
		.i_be   (r_be),
		.i_waddr(r_addr_q[msbp_pkg::MEM_AW:1]),
		.i_wdata(msbp_pkg::lane_fit(pins_s.ad, r_byte_q, 1'b0)),
		.i_raddr(r_addr_q[msbp_pkg::MEM_AW:1]),
		.o_rdata(mem_rdata)
	);

	// Extend the cycle while the read word is fetched
	assign o_wait_oe_n = ~((r_state_q == msbp_pkg::MSBP_R_SEL) & ds_fall & r_rd_q
		| (r_state_q == msbp_pkg::MSBP_R_RDWT));

	// ---------------- Pin drivers ----------------
	logic m_drive_ad;
	logic r_drive_ad;
	logic [msbp_pkg::AD_W-1:0] ad_d;
	logic [msbp_pkg::AD_W-1:0] ad_q;
	logic [1:0]                ad_oe_q;

	assign m_drive_ad = (m_state_q == msbp_pkg::MSBP_M_ADDR)
		| (m_state_q == msbp_pkg::MSBP_M_ASHI)
		| (~cur_q.rd & ((m_state_q == msbp_pkg::MSBP_M_DSLO)
		| (m_state_q == msbp_pkg::MSBP_M_DATA)
		| ((m_state_q == msbp_pkg::MSBP_M_END) & (cur_q.kind != msbp_pkg::MSBP_KIND_NULL))));
	assign r_drive_ad = (r_state_q == msbp_pkg::MSBP_R_DRV);

	always_comb begin
		ad_d = msbp_pkg::RST_WORD;
		if (m_state_q == msbp_pkg::MSBP_M_ADDR || m_state_q == msbp_pkg::MSBP_M_ASHI) begin
			ad_d = cur_q.addr;
		end else if (m_drive_ad) begin
			ad_d = msbp_pkg::lane_fit(cur_q.wdata, cur_q.byte_sz, 1'b0);
		end else if (r_drive_ad) begin
			ad_d = msbp_pkg::lane_fit(mem_rdata, r_byte_q, r_addr_q[0]);
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ad_q    <= msbp_pkg::RST_WORD;
			ad_oe_q <= {2{msbp_pkg::RST_OE_N}};
		end else begin
			ad_q       <= ad_d;
			ad_oe_q[0] <= ~(m_drive_ad | r_drive_ad);
			ad_oe_q[1] <= ~(m_drive_ad | r_drive_ad) | i_narrow_bus;
		end
	end

	assign o_mux_addr_data_lines = ad_q;
	assign o_ad_oe_n             = ad_oe_q;

	// Master control lines, registered from the sequencer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_addr_valid_strobe_n      <= msbp_pkg::RST_STROBE_N;
			o_transfer_timing_strobe_n <= msbp_pkg::RST_STROBE_N;
			o_rd                       <= msbp_pkg::RST_RD;
			o_byte_sz                  <= 1'b0;
			o_status                   <= '0;
			o_ctl_oe_n                 <= msbp_pkg::RST_OE_N;
		end else begin
			o_addr_valid_strobe_n      <= ~(m_state_q == msbp_pkg::MSBP_M_ADDR);
			o_transfer_timing_strobe_n <= ~((m_state_q == msbp_pkg::MSBP_M_DSLO)
				| (m_state_q == msbp_pkg::MSBP_M_DATA));
			o_rd                       <= cur_q.rd;
			o_byte_sz                  <= cur_q.byte_sz;
			o_status                   <= {cur_q.qual, cur_q.kind};
			o_ctl_oe_n                 <= ~(own_bus & ~bus_rst);
		end
	end

endmodule // msbp_port

// >>> verif/msbp_port_properties.sv
`timescale 1ns/1ns
module msbp_port_checker (
	// Clock, reset and straps
	input wire logic                 i_clk,
	input wire logic                 i_rst,
	input wire logic                 i_cpu_role,
	input wire logic                 i_narrow_bus,
	// Inputs watched
	input wire msbp_pkg::msbp_pins_t i_pins,
	input wire logic                 i_mreq_valid,
	input wire logic                 i_irq_req,
	// Outputs watched
	input wire logic [1:0]           o_ad_oe_n,
	input wire logic                 o_addr_valid_strobe_n,
	input wire logic                 o_transfer_timing_strobe_n,
	input wire logic                 o_rd,
	input wire logic [3:0]           o_status,
	input wire logic                 o_ctl_oe_n,
	input wire logic                 o_bus_ownership_request_oe_n,
	input wire logic                 o_bus_grant_ack_n,
	input wire logic                 o_grant_chain_out_n,
	input wire logic                 o_int_req_n,
	input wire logic                 o_mreq_ready,
	input wire logic                 o_mdone
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_narrow; i_narrow_bus |-> o_ad_oe_n[1]; endproperty
	a_narrow: assert property (p_narrow) else $error("high lane driven on narrow bus");
	property p_irq; o_int_req_n == !i_irq_req; endproperty
	a_irq: assert property (p_irq) else $error("interrupt line wrong");
	property p_start;
		$rose(o_addr_valid_strobe_n) |-> $stable(o_rd) && $stable(o_status) && !o_ctl_oe_n;
	endproperty
	a_start: assert property (p_start) else $error("lines moved at strobe rise");
	property p_strb; !o_transfer_timing_strobe_n |-> o_addr_valid_strobe_n; endproperty
	a_strb: assert property (p_strb) else $error("both strobes low");
	property p_chain;
		(!i_cpu_role && o_bus_ownership_request_oe_n && $stable(i_pins.grant_in_n))[*4]
			|-> o_grant_chain_out_n == i_pins.grant_in_n;
	endproperty
	a_chain: assert property (p_chain) else $error("grant chain not passed");
	property p_hold; !o_bus_ownership_request_oe_n |-> o_grant_chain_out_n; endproperty
	a_hold: assert property (p_hold) else $error("grant passed while requesting");
	property p_ack; $fell(o_bus_grant_ack_n) |-> o_ctl_oe_n && i_cpu_role; endproperty
	a_ack: assert property (p_ack) else $error("ack before bus released");
	property p_busy;
		!o_addr_valid_strobe_n || !o_transfer_timing_strobe_n |-> !o_mreq_ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready during transfer");
	property p_done;
		$rose(o_mdone) |-> o_addr_valid_strobe_n && o_transfer_timing_strobe_n ##1 !o_mdone;
	endproperty
	a_done: assert property (p_done) else $error("done pulse wrong");
	property p_req;
		!i_cpu_role && i_mreq_valid && o_ctl_oe_n |-> ##[0:4] !o_bus_ownership_request_oe_n;
	endproperty
	a_req: assert property (p_req) else $error("no ownership request");
	c_done: cover property (o_mdone);
	c_ack: cover property ($fell(o_bus_grant_ack_n));
	c_resp: cover property (o_ctl_oe_n && !o_ad_oe_n[0]);
endmodule // msbp_port_checker

bind msbp_port msbp_port_checker u_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_cpu_role(i_cpu_role), .i_narrow_bus(i_narrow_bus),
	.i_pins(i_pins), .i_mreq_valid(i_mreq_valid), .i_irq_req(i_irq_req),
	.o_ad_oe_n(o_ad_oe_n), .o_addr_valid_strobe_n(o_addr_valid_strobe_n),
	.o_transfer_timing_strobe_n(o_transfer_timing_strobe_n), .o_rd(o_rd),
	.o_status(o_status), .o_ctl_oe_n(o_ctl_oe_n), .o_int_req_n(o_int_req_n),
	.o_bus_ownership_request_oe_n(o_bus_ownership_request_oe_n),
	.o_bus_grant_ack_n(o_bus_grant_ack_n), .o_grant_chain_out_n(o_grant_chain_out_n),
	.o_mreq_ready(o_mreq_ready), .o_mdone(o_mdone)
);

// >>> verif/msbp_far_model.sv
`timescale 1ns/1ns
module msbp_far_model (
	// Resolved bus lines
	input  wire logic        i_en,
	input  wire logic        i_as_n,
	input  wire logic        i_ds_n,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_ad,
	input  wire logic [2:0]  i_waits,
	// Clock and answers
	output logic             o_bus_clk,
	output logic             o_wait_n,
	output logic [15:0]      o_ad,
	output logic [15:0]      o_last_wr
);
	logic [15:0] addr_q;
	logic [2:0]  cnt_q;
	initial o_bus_clk = 1'b0;
	always #40 o_bus_clk = ~o_bus_clk;
	// Address taken at the strobe rise
	always @(posedge i_as_n) addr_q = i_ad;
	always @(posedge i_ds_n) if (i_en && !i_rd) o_last_wr = i_ad;
	// Extension lasts the commanded number of falling bus clocks
	always @(negedge o_bus_clk) begin
		if (i_ds_n)
			cnt_q = i_waits;
		else if (cnt_q != 3'h0)
			cnt_q = cnt_q - 3'h1;
	end
	assign o_wait_n = !i_en || i_ds_n || cnt_q == 3'h0;
	// Read answer is the inverted address; released lines toggle
	assign o_ad = (i_en && !i_ds_n && i_rd) ? ~addr_q : {16{o_bus_clk}};
endmodule // msbp_far_model

// >>> verif/multiplexed_system_bus_port_bench.sv
`timescale 1ns/1ns
module multiplexed_system_bus_port_bench;
	logic i_clk = 1'b0, i_rst = 1'b1, cpu = 1'b1, narrow = 1'b0, mvalid = 1'b0, bdrv = 1'b0;
	logic [2:0] waits = 3'h0;
	msbp_pkg::msbp_mreq_t mreq = '0;
	msbp_pkg::msbp_pins_t bp, pins;
	logic [15:0] dad, fad, lastwr, mrdata;
	logic [1:0] oe;
	logic [3:0] st;
	logic das, dds, drd, ctl, wo, ro, ack, cho, fw, bclk, mready, mdone, bsz;
	int fail_count = 0, samples_checked = 0, cycles = 0, bcnt = 0;
	always #5 i_clk = ~i_clk;
	always @(posedge bclk) bcnt++;
	// Wire level from every party's enables
	always_comb begin
		pins = bp;
		pins.bus_clk = bclk;
		pins.wait_n = fw & wo;
		pins.bus_ownership_request_n_n = bp.bus_ownership_request_n_n & ro;
		if (!ctl) begin
			pins.as_n = das;
			pins.ds_n = dds;
			pins.rd = drd;
		end
		for (int i = 0; i < 2; i++)
			pins.ad[i*8+:8] = !oe[i] ? dad[i*8+:8] : bdrv ? bp.ad[i*8+:8] : fad[i*8+:8];
	end
	msbp_port DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_cpu_role(cpu), .i_narrow_bus(narrow), .i_pins(pins),
		.o_mux_addr_data_lines(dad), .o_ad_oe_n(oe), .o_addr_valid_strobe_n(das),
		.o_transfer_timing_strobe_n(dds), .o_rd(drd), .o_byte_sz(bsz), .o_status(st),
		.o_ctl_oe_n(ctl), .o_wait_oe_n(wo), .o_bus_ownership_request_oe_n(ro),
		.o_bus_grant_ack_n(ack), .o_grant_chain_out_n(cho), .o_int_req_n(),
		.i_mreq(mreq), .i_mreq_valid(mvalid), .o_mreq_ready(mready), .o_mdone(mdone),
		.o_mrdata(mrdata), .i_irq_req(!cpu)
	);
	msbp_far_model u_far (
		.i_en(!ctl), .i_as_n(pins.as_n), .i_ds_n(pins.ds_n), .i_rd(pins.rd), .i_ad(pins.ad),
		.i_waits(waits), .o_bus_clk(bclk), .o_wait_n(fw), .o_ad(fad), .o_last_wr(lastwr)
	);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic restart(input logic role, input logic nb);
		@(negedge i_clk);
		i_rst = 1'b1;
		cpu = role;
		narrow = nb;
		repeat (16) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask
	// Header is qualifier, kind, read, byte; counts bus clocks from take to done
	task automatic mop(input logic [5:0] h, input logic [15:0] a, input logic [15:0] w,
			input logic [15:0] exp, input int nclk);
		int t = 0;
		int b0;
		@(negedge i_clk);
		mreq = {h, a, w};
		mvalid = 1'b1;
		while (mready !== 1'b1 && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		while (mready !== 1'b0 && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		mvalid = 1'b0;
		b0 = bcnt;
		while (mdone !== 1'b1 && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		check(16'(bcnt - b0), 16'(nclk));
		check({11'h0, st, bsz}, {11'h0, h[5:2], h[0] | narrow});
		check((h[1] ? mrdata : lastwr) & {narrow ? 8'h00 : 8'hFF, 8'hFF}, exp);
	endtask
	// Bench as master, the port as memory; select dropped after the strobe rise
	task automatic pop(input logic rd, input logic cs, input logic [15:0] a,
			input logic [15:0] w, input logic [15:0] exp, input logic [1:0] eoe);
		@(negedge i_clk);
		bdrv = 1'b1;
		bp.as_n = 1'b0;
		bp.cs_n = cs;
		bp.rd = rd;
		bp.byte_sz = 1'b0;
		bp.status = 4'h2;
		bp.ad = a;
		repeat (4) @(negedge i_clk);
		bp.as_n = 1'b1;
		repeat (4) @(negedge i_clk);
		bp.cs_n = 1'b1;
		bp.ds_n = 1'b0;
		bp.ad = w;
		bdrv = !rd;
		repeat (2) @(negedge i_clk);
		check({15'h0, wo}, {15'h0, !(rd && !cs)});
		repeat (10) @(negedge i_clk);
		check({14'h0, oe}, {14'h0, eoe});
		if (eoe == 2'b00)
			check(pins.ad, exp);
		bp.ds_n = 1'b1;
		repeat (6) @(negedge i_clk);
		bdrv = 1'b0;
	endtask
	// Both strobes low part-way through a selected read abandon it
	task automatic strobe_clear;
		@(negedge i_clk);
		bdrv = 1'b1;
		bp.as_n = 1'b0;
		bp.cs_n = 1'b0;
		bp.rd = 1'b1;
		bp.ad = 16'h0006;
		repeat (4) @(negedge i_clk);
		bp.as_n = 1'b1;
		repeat (4) @(negedge i_clk);
		bp.cs_n = 1'b1;
		bp.as_n = 1'b0;
		bp.ds_n = 1'b0;
		bdrv = 1'b0;
		repeat (12) @(negedge i_clk);
		check({14'h0, oe}, 16'h0003);
		check({15'h0, wo}, 16'h0001);
		bp.as_n = 1'b1;
		bp.ds_n = 1'b1;
		repeat (6) @(negedge i_clk);
	endtask
	initial begin
		bp = '1;
		bp.status = 4'h0;
		restart(1'b1, 1'b0);
		mop(6'b01_10_0_0, 16'h0040, 16'hBEEF, 16'hBEEF, 5);
		mop(6'b00_01_1_0, 16'h1234, 16'h0000, 16'hEDCB, 5);
		mop(6'b10_10_0_1, 16'h0022, 16'h12A5, 16'hA5A5, 5);
		mop(6'b00_10_1_1, 16'h0F30, 16'h0000, 16'h00CF, 5);
		waits = 3'h3;
		mop(6'b01_10_0_0, 16'h0044, 16'h5A0F, 16'h5A0F, 6);
		waits = 3'h0;
		mop(6'b00_00_0_0, 16'h0000, 16'h0000, 16'h5A0F, 3);
		bp.bus_ownership_request_n_n = 1'b0;
		repeat (12) @(negedge i_clk);
		check({15'h0, ack}, 16'h0000);
		check({15'h0, ctl}, 16'h0001);
		bp.reset_n = 1'b0;
		repeat (8) @(negedge i_clk);
		check({15'h0, ack}, 16'h0001);
		bp.reset_n = 1'b1;
		bp.bus_ownership_request_n_n = 1'b1;
		restart(1'b1, 1'b1);
		mop(6'b01_10_0_1, 16'h0010, 16'h005A, 16'h005A, 5);
		restart(1'b0, 1'b0);
		bp.grant_in_n = 1'b0;
		repeat (6) @(negedge i_clk);
		check({15'h0, cho}, 16'h0000);
		bp.grant_in_n = 1'b1;
		fork
			mop(6'b01_10_0_0, 16'h0080, 16'h3C3C, 16'h3C3C, 5);
			begin
				repeat (8) @(negedge i_clk);
				check({15'h0, ro}, 16'h0000);
				check({15'h0, cho}, 16'h0001);
				bp.grant_in_n = 1'b0;
			end
		join
		bp.grant_in_n = 1'b1;
		repeat (20) @(negedge i_clk);
		check({15'h0, ro}, 16'h0001);
		pop(1'b0, 1'b0, 16'h0006, 16'hC3A1, 16'h0000, 2'b11);
		pop(1'b1, 1'b0, 16'h0006, 16'h0000, 16'hC3A1, 2'b00);
		pop(1'b0, 1'b1, 16'h0006, 16'h0000, 16'h0000, 2'b11);
		pop(1'b1, 1'b0, 16'h0006, 16'h0000, 16'hC3A1, 2'b00);
		strobe_clear();
		close_out();
	end
endmodule // multiplexed_system_bus_port_bench
